/* common/tmc_defines.svh */
// register offsets, field positions, reset values and tick widths
// assumes byte addressing on a 32-bit APB with aligned words
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
// ***************************
// register offsets
// ***************************
`define TMC_OFS_SRC0 8'h00
`define TMC_OFS_SRC1 8'h04
`define TMC_OFS_SRC2 8'h08
`define TMC_OFS_MODE0 8'h0C
`define TMC_OFS_MODE1 8'h10
`define TMC_OFS_MODE2 8'h14
`define TMC_OFS_IO0H 8'h18
`define TMC_OFS_IO0L 8'h1C
`define TMC_OFS_IO1 8'h20
`define TMC_OFS_IO2 8'h24
`define TMC_OFS_CNT0 8'h28
`define TMC_OFS_CNT1 8'h2C
`define TMC_OFS_CNT2 8'h30
// ***************************
// fields and reset values
// ***************************
`define TMC_MODE_RESET 8'hC0
`define TMC_MODE_FIXED 8'hC0
`define TMC_IO_RESET 8'h00
`define TMC_SRC_RESET 3'h0
`define TMC_BIT_PAIR_BD 5
`define TMC_BIT_PAIR_AC 4
`define TMC_ROLE_OFF0 4'h0
`define TMC_ROLE_OFF1 4'h4
// prescaler width: largest internal divider is 1024
`define TMC_PRE_W 10
`endif

/* common/tmc_pkg.sv */
// types shared by the mode configuration block
// assumes nothing beyond the defines header
package tmc_pkg;
  // decoded operating mode of one channel
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PWM1 = 3'h1,
    MODE_PWM2 = 3'h3,
    MODE_PHASE1 = 3'h2,
    MODE_PHASE2 = 3'h6,
    MODE_PHASE3 = 3'h7,
    MODE_PHASE4 = 3'h5,
    MODE_RESERVED = 3'h4
  } tmc_mode_e;
  // effective role of one general register
  typedef struct packed {
    logic [3:0] code;
    logic active;
    logic buffer;
  } tmc_role_s;
endpackage : tmc_pkg

/* core/tmc_core.sv */
// mode, clock source and i/o role configuration of a three-channel timer
// assumes an APB master on clk, pins synchronous to clk, standby as a pulse
//
// Chosen here: the APB slave port and the register addresses.
`include "tmc_defines.svh"
// Operation
// RULE1 - channel 0 sources: div 1,4,16,64 then pins A to D; default 000
// RULE2 - channel 1 sources: div 1..64, pins A,B, div 256, channel 2 wrap
// RULE3 - channel 2 sources: div 1..64, pins A,B,C, then div 1024
// RULE4 - phase counting on channel 1 or 2 ignores its source select
// RULE5 - mode registers reset to C0 on reset and standby entry
// RULE6 - mode bits 7 and 6 always read one; software writes ones
// RULE7 - channel 0 bit 5 pairs B with D; D then never matches or captures
// RULE8 - channel 0 bit 4 pairs A with C; C then never matches or captures
// RULE9 - channels 1 and 2 pairing bits read zero, cannot change
// RULE10 - mode field: 0 normal, 2 pwm1, 3 pwm2, 4 to 7 phase 1 to 4
// RULE11 - software never writes mode 0001 or codes with top bit set
// RULE12 - software never selects phase counting on channel 0
// RULE13 - four i/o control registers, all cleared on reset and standby
// RULE14 - high nibble sets register B (or D), low nibble A (or C)
// RULE15 - buffered C or D ignores its i/o control setting
// RULE16 - each i/o code selects disabled, compare output or capture role
// RULE17 - counter steps once per source event; new select applies next cycle
module tmc_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic standbyEntry,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClockPinA,
  input wire logic extClockPinB,
  input wire logic extClockPinC,
  input wire logic extClockPinD,
  output tmc_pkg::tmc_mode_e mode0,
  output tmc_pkg::tmc_mode_e mode1,
  output tmc_pkg::tmc_mode_e mode2,
  output tmc_pkg::tmc_role_s role0A,
  output tmc_pkg::tmc_role_s role0B,
  output tmc_pkg::tmc_role_s role0C,
  output tmc_pkg::tmc_role_s role0D,
  output tmc_pkg::tmc_role_s role1A,
  output tmc_pkg::tmc_role_s role1B,
  output tmc_pkg::tmc_role_s role2A,
  output tmc_pkg::tmc_role_s role2B,
  output logic [15:0] channel0Counter,
  output logic [15:0] channel1Counter,
  output logic [15:0] channel2Counter
);
  // ***************************
  // register state
  // ***************************
  logic [2:0] srcSel0, srcSel1, srcSel2;
  logic [5:0] modeBits0;
  logic [3:0] modeBits1, modeBits2;
  logic [7:0] ioCtl0High, ioCtl0Low, ioCtl1, ioCtl2;
  logic [2:0] next_srcSel0, next_srcSel1, next_srcSel2;
  logic [5:0] next_modeBits0;
  logic [3:0] next_modeBits1, next_modeBits2;
  logic [7:0] next_ioCtl0High, next_ioCtl0Low, next_ioCtl1, next_ioCtl2;
  logic [31:0] readData, next_readData;
  logic readErr, next_readErr;
  logic wrEn;
  logic mapped;
  logic [31:0] readMux;

  assign wrEn = psel & penable & pwrite;
  // zero wait state: read data is caught at the setup edge
  assign pready = psel & penable;
  assign pslverr = psel & penable & readErr;
  assign prdata = readData;

  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      `TMC_OFS_SRC0: readMux[2:0] = srcSel0;
      `TMC_OFS_SRC1: readMux[2:0] = srcSel1;
      `TMC_OFS_SRC2: readMux[2:0] = srcSel2;
      `TMC_OFS_MODE0: readMux[7:0] = `TMC_MODE_FIXED | {2'h0, modeBits0}; // RULE6
      `TMC_OFS_MODE1: readMux[7:0] = `TMC_MODE_FIXED | {4'h0, modeBits1}; // RULE9
      `TMC_OFS_MODE2: readMux[7:0] = `TMC_MODE_FIXED | {4'h0, modeBits2}; // RULE9
      `TMC_OFS_IO0H: readMux[7:0] = ioCtl0High;
      `TMC_OFS_IO0L: readMux[7:0] = ioCtl0Low;
      `TMC_OFS_IO1: readMux[7:0] = ioCtl1;
      `TMC_OFS_IO2: readMux[7:0] = ioCtl2;
      `TMC_OFS_CNT0: readMux[15:0] = channel0Counter;
      `TMC_OFS_CNT1: readMux[15:0] = channel1Counter;
      `TMC_OFS_CNT2: readMux[15:0] = channel2Counter;
      default: mapped = 1'b0;
    endcase
  end

  // register writes; standby entry wins over a write in the same cycle
  always_comb begin
    next_srcSel0 = srcSel0;
    next_srcSel1 = srcSel1;
    next_srcSel2 = srcSel2;
    next_modeBits0 = modeBits0;
    next_modeBits1 = modeBits1;
    next_modeBits2 = modeBits2;
    next_ioCtl0High = ioCtl0High;
    next_ioCtl0Low = ioCtl0Low;
    next_ioCtl1 = ioCtl1;
    next_ioCtl2 = ioCtl2;
    next_readData = readData;
    next_readErr = readErr;
    if (psel && !penable) begin
      next_readData = readMux;
      next_readErr = ~mapped;
    end
    if (wrEn) begin
      case (paddr)
        `TMC_OFS_SRC0: next_srcSel0 = pwdata[2:0];
        `TMC_OFS_SRC1: next_srcSel1 = pwdata[2:0];
        `TMC_OFS_SRC2: next_srcSel2 = pwdata[2:0];
        `TMC_OFS_MODE0: next_modeBits0 = pwdata[5:0]; // RULE7 RULE8
        `TMC_OFS_MODE1: next_modeBits1 = pwdata[3:0]; // RULE9
        `TMC_OFS_MODE2: next_modeBits2 = pwdata[3:0]; // RULE9
        `TMC_OFS_IO0H: next_ioCtl0High = pwdata[7:0];
        `TMC_OFS_IO0L: next_ioCtl0Low = pwdata[7:0];
        `TMC_OFS_IO1: next_ioCtl1 = pwdata[7:0];
        `TMC_OFS_IO2: next_ioCtl2 = pwdata[7:0];
        default: next_readErr = readErr;
      endcase
    end
    if (standbyEntry) begin
      next_srcSel0 = `TMC_SRC_RESET;
      next_srcSel1 = `TMC_SRC_RESET;
      next_srcSel2 = `TMC_SRC_RESET;
      next_modeBits0 = 6'h00; // RULE5
      next_modeBits1 = 4'h0; // RULE5
      next_modeBits2 = 4'h0; // RULE5
      next_ioCtl0High = `TMC_IO_RESET; // RULE13
      next_ioCtl0Low = `TMC_IO_RESET; // RULE13
      next_ioCtl1 = `TMC_IO_RESET; // RULE13
      next_ioCtl2 = `TMC_IO_RESET; // RULE13
    end
  end

  // register file flops; clkEn freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srcSel0 <= `TMC_SRC_RESET;
      srcSel1 <= `TMC_SRC_RESET;
      srcSel2 <= `TMC_SRC_RESET;
      modeBits0 <= 6'h00; // RULE5
      modeBits1 <= 4'h0;
      modeBits2 <= 4'h0;
      ioCtl0High <= `TMC_IO_RESET; // RULE13
      ioCtl0Low <= `TMC_IO_RESET;
      ioCtl1 <= `TMC_IO_RESET;
      ioCtl2 <= `TMC_IO_RESET;
      readData <= 32'h0000_0000;
      readErr <= 1'b0;
    end else if (clkEn) begin
      srcSel0 <= next_srcSel0;
      srcSel1 <= next_srcSel1;
      srcSel2 <= next_srcSel2;
      modeBits0 <= next_modeBits0;
      modeBits1 <= next_modeBits1;
      modeBits2 <= next_modeBits2;
      ioCtl0High <= next_ioCtl0High;
      ioCtl0Low <= next_ioCtl0Low;
      ioCtl1 <= next_ioCtl1;
      ioCtl2 <= next_ioCtl2;
      readData <= next_readData;
      readErr <= next_readErr;
    end
  end

  // ***************************
  // mode and role decode
  // ***************************
  function automatic tmc_pkg::tmc_mode_e decodeMode(
    input logic [3:0] code,
    input logic phaseOk
  );
    case (code) // RULE10
      4'h0: decodeMode = tmc_pkg::MODE_NORMAL;
      4'h2: decodeMode = tmc_pkg::MODE_PWM1;
      4'h3: decodeMode = tmc_pkg::MODE_PWM2;
      4'h4: decodeMode = phaseOk ? tmc_pkg::MODE_PHASE1
                                 : tmc_pkg::MODE_RESERVED; // RULE12
      4'h5: decodeMode = phaseOk ? tmc_pkg::MODE_PHASE2
                                 : tmc_pkg::MODE_RESERVED;
      4'h6: decodeMode = phaseOk ? tmc_pkg::MODE_PHASE3
                                 : tmc_pkg::MODE_RESERVED;
      4'h7: decodeMode = phaseOk ? tmc_pkg::MODE_PHASE4
                                 : tmc_pkg::MODE_RESERVED;
      default: decodeMode = tmc_pkg::MODE_RESERVED; // RULE11
    endcase
  endfunction : decodeMode

  // disabled codes give no compare or capture; buffers never do
  function automatic tmc_pkg::tmc_role_s makeRole(
    input logic [3:0] code,
    input logic buffered
  );
    makeRole.code = code; // RULE16
    makeRole.active = ~buffered & (code != `TMC_ROLE_OFF0)
                      & (code != `TMC_ROLE_OFF1); // RULE15
    makeRole.buffer = buffered;
  endfunction : makeRole

  assign mode0 = decodeMode(modeBits0[3:0], 1'b0);
  assign mode1 = decodeMode(modeBits1, 1'b1);
  assign mode2 = decodeMode(modeBits2, 1'b1);
  // nibble split of the i/o control registers
  assign role0A = makeRole(ioCtl0High[3:0], 1'b0); // RULE14
  assign role0B = makeRole(ioCtl0High[7:4], 1'b0); // RULE14
  assign role0C = makeRole(ioCtl0Low[3:0],
                           modeBits0[`TMC_BIT_PAIR_AC]); // RULE8 RULE15
  assign role0D = makeRole(ioCtl0Low[7:4],
                           modeBits0[`TMC_BIT_PAIR_BD]); // RULE7 RULE15
  assign role1A = makeRole(ioCtl1[3:0], 1'b0);
  assign role1B = makeRole(ioCtl1[7:4], 1'b0);
  assign role2A = makeRole(ioCtl2[3:0], 1'b0);
  assign role2B = makeRole(ioCtl2[7:4], 1'b0);

  // ***************************
  // count sources and counters
  // ***************************
  logic [`TMC_PRE_W-1:0] preCnt, next_preCnt;
  logic [3:0] pinPrev, next_pinPrev;
  logic [3:0] pinNow, pinRise;
  logic tick4, tick16, tick64, tick256, tick1024;
  logic ev0, ev1, ev2, up1, up2, wrap2;
  logic phase1, phase2;
  logic [15:0] next_cnt0, next_cnt1, next_cnt2;

  assign pinNow = {extClockPinD, extClockPinC, extClockPinB, extClockPinA};
  // pins are synchronous, so one flop is enough for edge detect
  assign pinRise = pinNow & ~pinPrev;
  assign tick4 = &preCnt[1:0];
  assign tick16 = &preCnt[3:0];
  assign tick64 = &preCnt[5:0];
  assign tick256 = &preCnt[7:0];
  assign tick1024 = &preCnt[9:0];
  assign phase1 = modeBits1[2] & ~modeBits1[3];
  assign phase2 = modeBits2[2] & ~modeBits2[3];

  // source selection per channel
  always_comb begin
    case (srcSel0) // RULE1
      3'h0: ev0 = 1'b1;
      3'h1: ev0 = tick4;
      3'h2: ev0 = tick16;
      3'h3: ev0 = tick64;
      3'h4: ev0 = pinRise[0];
      3'h5: ev0 = pinRise[1];
      3'h6: ev0 = pinRise[2];
      default: ev0 = pinRise[3];
    endcase
    case (srcSel2) // RULE3
      3'h0: ev2 = 1'b1;
      3'h1: ev2 = tick4;
      3'h2: ev2 = tick16;
      3'h3: ev2 = tick64;
      3'h4: ev2 = pinRise[0];
      3'h5: ev2 = pinRise[1];
      3'h6: ev2 = pinRise[2];
      default: ev2 = tick1024;
    endcase
    up2 = 1'b1;
    // simple phase count: pin C edges, pin D level gives direction
    if (phase2) begin
      ev2 = pinRise[2]; // RULE4
      up2 = ~pinNow[3];
    end
    wrap2 = ev2 & (up2 ? (&channel2Counter) : (channel2Counter == 16'h0));
    case (srcSel1) // RULE2
      3'h0: ev1 = 1'b1;
      3'h1: ev1 = tick4;
      3'h2: ev1 = tick16;
      3'h3: ev1 = tick64;
      3'h4: ev1 = pinRise[0];
      3'h5: ev1 = pinRise[1];
      3'h6: ev1 = tick256;
      default: ev1 = wrap2;
    endcase
    up1 = 1'b1;
    if (phase1) begin
      ev1 = pinRise[0]; // RULE4
      up1 = ~pinNow[1];
    end
  end

  // counter next values, one step per event
  always_comb begin
    next_preCnt = preCnt + 1'b1;
    next_pinPrev = pinNow;
    next_cnt0 = ev0 ? channel0Counter + 16'h1 : channel0Counter; // RULE17
    next_cnt1 = channel1Counter;
    next_cnt2 = channel2Counter;
    if (ev1) begin
      next_cnt1 = up1 ? channel1Counter + 16'h1
                      : channel1Counter - 16'h1; // RULE17
    end
    if (ev2) begin
      next_cnt2 = up2 ? channel2Counter + 16'h1
                      : channel2Counter - 16'h1; // RULE17
    end
  end

  // counter flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCnt <= '0;
      pinPrev <= 4'h0;
      channel0Counter <= 16'h0000;
      channel1Counter <= 16'h0000;
      channel2Counter <= 16'h0000;
    end else if (clkEn) begin
      preCnt <= next_preCnt;
      pinPrev <= next_pinPrev;
      channel0Counter <= next_cnt0;
      channel1Counter <= next_cnt1;
      channel2Counter <= next_cnt2;
    end
  end
endmodule : tmc_core

/* testbench/tmc_core_assertions.sv */
// concurrent checks on the mode configuration block ports
// assumes the defines header and tmc_pkg are compiled first
`include "tmc_defines.svh"
module tmc_core_assertions (
  input logic clk,
  input logic rst_b,
  input logic clkEn,
  input logic standbyEntry,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input tmc_pkg::tmc_mode_e mode0,
  input tmc_pkg::tmc_mode_e mode1,
  input tmc_pkg::tmc_role_s role0C,
  input tmc_pkg::tmc_role_s role0D,
  input tmc_pkg::tmc_role_s role1B,
  input logic [15:0] channel0Counter
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***************************
  // properties
  // ***************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic wrM0;
  logic rdAcc;
  // committed write to the channel 0 mode word, standby wins
  assign wrM0 = psel && penable && pwrite && clkEn && !standbyEntry &&
    paddr == `TMC_OFS_MODE0;
  assign rdAcc = psel && penable && !pwrite;
  AST_STBY_MODE: assert property (
    standbyEntry && clkEn |=> mode0 == tmc_pkg::MODE_NORMAL &&
    mode1 == tmc_pkg::MODE_NORMAL) else $error("mode kept over standby");
  AST_STBY_IO: assert property (
    standbyEntry && clkEn |=> role0C.code == 4'h0 && role0D.code == 4'h0 &&
    role1B.code == 4'h0) else $error("io role kept over standby");
  AST_FIXED_ONES: assert property (
    rdAcc && paddr == `TMC_OFS_MODE0 |-> prdata[7:6] == 2'h3)
    else $error("mode bits 7:6 not read as one");
  AST_RSV_PAIR: assert property (
    rdAcc && (paddr == `TMC_OFS_MODE1 || paddr == `TMC_OFS_MODE2)
    |-> prdata[7:4] == 4'hC) else $error("ch1/2 pairing bits not zero");
  AST_PAIR_BD: assert property (
    wrM0 |=> role0D.buffer == $past(pwdata[5]))
    else $error("pairing b/d not following bit 5");
  AST_PAIR_AC: assert property (
    wrM0 |=> role0C.buffer == $past(pwdata[4]))
    else $error("pairing a/c not following bit 4");
  AST_BUF_QUIET: assert property (
    !(role0C.buffer && role0C.active) && !(role0D.buffer && role0D.active))
    else $error("buffer register still active");
  AST_ROLE_OFF: assert property (
    role1B.active == !(role1B.code inside {4'h0, 4'h4}))
    else $error("disabled role code reported active");
  AST_CH0_PHASE: assert property (
    !(mode0 inside {tmc_pkg::MODE_PHASE1, tmc_pkg::MODE_PHASE2,
    tmc_pkg::MODE_PHASE3, tmc_pkg::MODE_PHASE4}))
    else $error("phase counting decoded on channel 0");
  AST_CNT_STEP: assert property (
    $changed(channel0Counter) |->
    channel0Counter == $past(channel0Counter) + 16'h1)
    else $error("counter moved by other than one");
endmodule : tmc_core_assertions
bind tmc_core tmc_core_assertions tmc_core_assertions_i (.clk, .rst_b,
  .clkEn, .standbyEntry, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .mode0, .mode1, .role0C, .role0D, .role1B, .channel0Counter);

/* testbench/tmc_pin_model.sv */
// external count clock pins feeding the timer
// assumes pins sampled on clk rising edges
module tmc_pin_model (
  input wire logic clk,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***************************
  // pulse trains
  // ***************************
  // pins rest low between trains, so no stray edges reach the counters
  initial pins = 4'h0;
  // one rising edge per pulse, high two cycles, low two
  task pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      pins[idx] <= 1'b1;
      repeat (2) @(posedge clk);
      pins[idx] <= 1'b0;
      @(posedge clk);
    end
  endtask : pulse
endmodule : tmc_pin_model

/* testbench/tb_tmc_core.sv */
// self-checking bench for the mode configuration block
// assumes design, package, checker and pin model compiled before it
`include "tmc_defines.svh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin \
  errorCnt++; $display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end
module tb_tmc_core;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, standbyEntry = 1'b0, err, pready, pslverr;
  logic clkEn = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d, a;
  logic [15:0] cnt0, cnt1, cnt2, ex;
  wire logic [3:0] pins;
  tmc_pkg::tmc_mode_e mode0, mode1, mode2;
  tmc_pkg::tmc_role_s role0A, role0B, role0C, role0D;
  tmc_pkg::tmc_role_s role1A, role1B, role2A, role2B;
  int errorCnt = 0, totalChecks = 0, n;
  tmc_pkg::tmc_mode_e e1[8] = '{tmc_pkg::MODE_NORMAL,
    tmc_pkg::MODE_RESERVED, tmc_pkg::MODE_PWM1, tmc_pkg::MODE_PWM2,
    tmc_pkg::MODE_PHASE1, tmc_pkg::MODE_PHASE2, tmc_pkg::MODE_PHASE3,
    tmc_pkg::MODE_PHASE4};
  // ***************************
  // environment
  // ***************************
  // 40 MHz clock
  always #12.5 clk = ~clk;
  tmc_core tmc_core_i (.clk, .rst_b, .clkEn, .standbyEntry, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .extClockPinA(pins[0]), .extClockPinB(pins[1]), .extClockPinC(pins[2]),
    .extClockPinD(pins[3]), .mode0, .mode1, .mode2, .role0A, .role0B,
    .role0C, .role0D, .role1A, .role1B, .role2A, .role2B,
    .channel0Counter(cnt0), .channel1Counter(cnt1), .channel2Counter(cnt2));
  tmc_pin_model tmc_pin_model_i (.clk, .pins);
  // one apb transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] ad,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0, d);
    `CHK(d, e)
  endtask : rc
  // write, then let the register settle before outputs are looked at
  task automatic wm(input logic [7:0] ad, input logic [31:0] v);
    xfer(1'b1, ad, v, d);
    @(negedge clk);
  endtask : wm
  // counter delta over span edges between two read setups, or pulses
  task automatic meas(input logic [7:0] src, cnt, input logic [2:0] c,
    input int span, pin, np, input logic [15:0] e);
    xfer(1'b1, src, {29'h0, c}, d);
    xfer(1'b0, cnt, 32'h0, a);
    if (np > 0) begin
      tmc_pin_model_i.pulse(pin, np);
      repeat (2) @(posedge clk);
    end else begin
      repeat (span - 3) @(posedge clk);
    end
    xfer(1'b0, cnt, 32'h0, d);
    `CHK(d[15:0] - a[15:0], e)
  endtask : meas
  task automatic testDone;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : testDone
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    testDone();
  end
  // ***************************
  // tests
  // ***************************
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rc(8'(4 * i), (i > 2 && i < 6) ? 32'hC0 : 32'h0);
    end
    // software keeps ones in bits 7:6 and zeros in reserved pairing bits
    wm(`TMC_OFS_MODE0, 32'hF3);
    rc(`TMC_OFS_MODE0, 32'hF3);
    wm(`TMC_OFS_MODE1, 32'hC4);
    rc(`TMC_OFS_MODE1, 32'hC4);
    // reserved code 1 skipped; channel 0 keeps its last legal mode
    for (int c = 0; c < 8; c++) begin
      if (c != 1) begin
        if (c < 4) begin
          wm(`TMC_OFS_MODE0, 32'hC0 | c);
        end
        wm(`TMC_OFS_MODE1, 32'hC0 | c);
        `CHK(mode0, e1[c > 3 ? 3 : c])
        `CHK(mode1, e1[c])
      end
    end
    wm(`TMC_OFS_MODE2, 32'hC6);
    `CHK(mode2, tmc_pkg::MODE_PHASE3)
    // phase counting with idle pins must not count the fast source
    wm(`TMC_OFS_MODE1, 32'hC4);
    meas(`TMC_OFS_SRC1, `TMC_OFS_CNT1, 3'h0, 64, 0, 0, 16'h0);
    wm(`TMC_OFS_IO0H, 32'h5A);
    `CHK({role0B.code, role0A.code}, 8'h5A)
    wm(`TMC_OFS_IO0L, 32'h8B);
    `CHK({role0D.code, role0C.code}, 8'h8B)
    `CHK({role0D.active, role0C.active}, 2'h3)
    wm(`TMC_OFS_IO1, 32'h40);
    `CHK({role1B.active, role1A.active}, 2'h0)
    wm(`TMC_OFS_IO2, 32'h1C);
    `CHK({role2B.code, role2A.active}, 5'h3)
    wm(`TMC_OFS_MODE0, 32'hF0);
    `CHK({role0D.buffer, role0D.active}, 2'h2)
    `CHK({role0C.buffer, role0C.active}, 2'h2)
    rc(`TMC_OFS_IO0L, 32'h8B);
    // unmapped and misaligned places answer with an error and zero
    xfer(1'b1, 8'h34, 32'hFF, d);
    xfer(1'b0, 8'h0D, 32'h0, d);
    `CHK({err, d}, 33'h100000000)
    @(posedge clk);
    standbyEntry <= 1'b1;
    @(posedge clk);
    standbyEntry <= 1'b0;
    rc(`TMC_OFS_MODE0, 32'hC0);
    rc(`TMC_OFS_IO0L, 32'h0);
    // frozen clock enable holds the counter: 4 live edges of 13
    xfer(1'b0, `TMC_OFS_CNT0, 32'h0, a);
    @(posedge clk);
    clkEn <= 1'b0;
    repeat (2) @(negedge clk);
    ex = cnt0;
    repeat (8) @(posedge clk);
    `CHK(cnt0, ex)
    clkEn <= 1'b1;
    xfer(1'b0, `TMC_OFS_CNT0, 32'h0, d);
    `CHK(d[15:0] - a[15:0], 16'h4)
    for (int c = 0; c < 8; c++) begin
      n = c > 3 ? 3 : 0;
      ex = c > 3 ? 16'h3 : 16'(64 >> (2 * c));
      meas(`TMC_OFS_SRC0, `TMC_OFS_CNT0, 3'(c), 64, c - 4, n, ex);
    end
    meas(`TMC_OFS_SRC1, `TMC_OFS_CNT1, 3'h6, 256, 0, 0, 16'h1);
    meas(`TMC_OFS_SRC1, `TMC_OFS_CNT1, 3'h5, 0, 1, 2, 16'h2);
    meas(`TMC_OFS_SRC2, `TMC_OFS_CNT2, 3'h7, 1024, 0, 0, 16'h1);
    meas(`TMC_OFS_SRC2, `TMC_OFS_CNT2, 3'h6, 0, 2, 2, 16'h2);
    // idle pins: counter ports must match what the bus reads back
    xfer(1'b0, `TMC_OFS_CNT1, 32'h0, a);
    `CHK({cnt2, cnt1}, {d[15:0], a[15:0]})
    testDone();
  end
endmodule : tb_tmc_core
